// file: bench/lis_idle_ctrl_tb.sv
// self-checking bench for the light idle standby controller
`timescale 1ns/1ns
`default_nettype none
module lis_idle_ctrl_tb;
    import lis_pkg::*;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    lis_req_type raise = '0;
    lis_req_type req;
    lis_cpu_type cpu = '0;
    lis_gate_type gate;
    logic clr = 1'b0;
    logic idle;
    logic ack_nmi;
    logic ack_mask;
    logic sys_rst;
    logic [31:0] q;
    logic [12:0] cs = 13'h0;
    logic [15:0] seed = 16'h5310;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    always #20 i_clk = ~i_clk;

    lis_idle_ctrl u_lis_idle_ctrl (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_req(req), .i_cpu(cpu), .o_gate(gate), .o_idle(idle),
        .o_ack_nmi(ack_nmi), .o_ack_mask(ack_mask), .o_sys_reset(sys_rst));

    lis_irq_model u_lis_irq_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_raise(raise), .i_clear(clr), .i_ack_nmi(ack_nmi),
        .i_ack_mask(ack_mask), .o_req(req));

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function lis_gate_type exp_gate(input logic id, input logic [12:0] c);
        lis_gate_type g;
        g = '1;
        {g.adc_hold, g.dac_hold, g.rto_hold, g.port_hold} = {4{id}};
        if (id) begin
            {g.cpu_clk_en, g.dma_clk_en, g.timer_pq_clk_en} = '0;
            {g.iic_clk_en, g.uartc_clk_en, g.crc_clk_en} = '0;
            g.intc_clk_en = 1'b0;
            g.timer_m_clk_en = c[0] | (c[6] & c[1]);
            g.wdt2_clk_en = c[2] | (c[6] & c[3]);
            g.watch_clk_en = c[4] | c[6];
            g.csi_clk_en = c[12:8];
            g.uart0_clk_en = c[5];
            g.uart_other_clk_en = 1'b0;
        end
        return g;
    endfunction : exp_gate

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string m);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s seen %h want %h", $time, m, seen, exp);
        end
    endtask : check

    // the bus holds the request until ack is sampled, then idles a cycle
    task wb(input logic w, input logic [3:0] a, input logic [3:0] s,
            input logic [31:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        // wait until ack is sampled high; only the bench timeout ends a wait with no ack
        do begin
            @(posedge i_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // x holds {idle after, nmi ack, maskable ack, system reset}
    task wc(input logic en, input logic [2:0] m, input lis_cpu_type c,
            input lis_req_type r, input logic [3:0] x);
        logic [2:0] seen;
        int t;
        lis_gate_type g;
        seen = '0;
        t = 0;
        cpu <= c;
        if (en) begin
            wb(1'b1, 4'h0, 4'hF, {28'h0, 1'b1, m});
            @(posedge i_clk);
            #1;
            check(idle, 1'b1, "entry");
            g = exp_gate(1'b1, cs);
            check(gate, g, "idle gates");
            check(gate.csi_clk_en, cs[12:8], "csi");
            check(gate.uart0_clk_en, cs[5], "uart0");
            check(gate.dac_hold, 1'b1, "dac");
            check(gate.rto_hold, 1'b1, "rto");
            check(gate.key_int_en, 1'b1, "key");
            check(gate.port_hold, 1'b1, "ports");
        end
        @(posedge i_clk);
        raise <= r;
        @(posedge i_clk);
        raise <= '0;
        for (int i = 1; i < 7; i++) begin
            #1;
            seen |= {ack_nmi, ack_mask, sys_rst};
            if (idle !== 1'b1 && t == 0) t = i;
            @(posedge i_clk);
        end
        check({idle, seen}, x, "wake outcome");
        if (!x[3]) check(t, 2, "exit delay");
        check(gate, exp_gate(x[3], cs), "gates after");
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
    endtask : wc

    task finish_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wb(1'b0, 4'h1, 4'hF, 32'h0);
        check(q, 32'h3, "mode reset");
        wb(1'b0, 4'h2, 4'hF, 32'h0);
        check(q, 32'h0, "clksel reset");
        wb(1'b1, 4'h9, 4'hF, 32'hFFFFFFFF);
        wb(1'b0, 4'h9, 4'hF, 32'h0);
        check(q, 32'h0, "unmapped read");
        wb(1'b1, 4'h1, 4'h0, 32'h0);
        wb(1'b0, 4'h1, 4'hF, 32'h0);
        check(q, 32'h3, "write without sel");
        $display("test registers done");
        wb(1'b1, 4'h1, 4'hF, 32'h0);
        wc(1'b1, 3'h0, 5'h00, 8'h80, 4'h4);
        wc(1'b1, 3'h0, 5'h10, 8'h40, 4'h4);
        wc(1'b1, 3'h0, 5'h00, 8'h30, 4'h0);
        wc(1'b1, 3'h0, 5'h19, 8'h30, 4'h0);
        wc(1'b1, 3'h0, 5'h1D, 8'h28, 4'h2);
        wc(1'b1, 3'h0, 5'h10, 8'h82, 4'h0);
        wc(1'b1, 3'h7, 5'h10, 8'hE0, 4'h8);
        wc(1'b0, 3'h0, 5'h10, 8'h01, 4'h1);
        for (int k = 0; k < 3; k++) begin
            wc(1'b1, 3'h1 << k, 5'h10, 8'h20 << k, 4'h8);
            wc(1'b0, 3'h0, 5'h10, 8'h01, 4'h1);
            wb(1'b1, 4'h1, 4'hF, 32'h0);
        end
        $display("test wake table done");
        raise <= 8'h30;
        @(posedge i_clk);
        raise <= '0;
        wb(1'b1, 4'h0, 4'hF, 32'h8);
        @(posedge i_clk);
        #1;
        check(idle, 1'b0, "entry refused");
        wb(1'b0, 4'h3, 4'hF, 32'h0);
        check(q[0], 1'b1, "refused flag");
        check(q[8:1], 8'h06, "wake count");
        wb(1'b1, 4'h3, 4'hF, 32'h0);
        wb(1'b0, 4'h3, 4'hF, 32'h0);
        check(q[0], 1'b0, "refused flag cleared");
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        $display("test pending entry done");
        for (int j = 0; j < 6; j++) begin
            seed = lfsr(seed);
            cs = seed[12:0] & 13'h1F7F;
            wb(1'b1, 4'h2, 4'hF, {19'h0, cs});
            wb(1'b0, 4'h2, 4'hF, 32'h0);
            check(q, {19'h0, cs}, "clksel readback");
            wc(1'b1, 3'h0, 5'h10, 8'h40, 4'h4);
        end
        $display("test clock select done");
        finish_test();
    end
endmodule : lis_idle_ctrl_tb
`default_nettype wire

// file: bench/lis_irq_model.sv
// interrupt source side model for the light idle controller
`timescale 1ns/1ns
`default_nettype none
module lis_irq_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire lis_pkg::lis_req_type i_raise,
    input wire logic i_clear,
    input wire logic i_ack_nmi,
    input wire logic i_ack_mask,
    output lis_pkg::lis_req_type o_req
);
    import lis_pkg::*;
    // ****************************************
    // pending requests
    // ****************************************
    // a raised request stays pending until acknowledged or withdrawn,
    // as a real interrupt controller keeps an unserved source
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req <= '0;
        end else if (i_clear) begin
            o_req <= '0;
        end else begin
            o_req <= o_req | i_raise;
            if (i_ack_nmi) begin
                o_req.wdt_nmi <= 1'b0;
                o_req.pin_nmi <= 1'b0;
            end
            if (i_ack_mask) begin
                o_req.maskable <= 1'b0;
            end
        end
    end
endmodule : lis_irq_model
`default_nettype wire

// file: logic/lis_defines.svh
// constants of the light idle standby controller
`ifndef LIS_DEFINES_SVH
`define LIS_DEFINES_SVH
`define LIS_ADR_CTRL 4'h0
`define LIS_ADR_MODE 4'h1
`define LIS_ADR_CLKSEL 4'h2
`define LIS_ADR_STATUS 4'h3
`define LIS_ADR_CPUCTX 4'h4
`define LIS_MODE_LIGHT 2'h0
`define LIS_CTRL_TRIG 3
`define LIS_CTRL_WATCHDOG_NMI_RELEASE_MASK 2
`define LIS_CTRL_PIN_NMI_RELEASE_MASK 1
`define LIS_CTRL_MASKABLE_RELEASE_MASK 0
`define LIS_CS_TMM_FR8 0
`define LIS_CS_TMM_SUB 1
`define LIS_CS_WDT_FR8 2
`define LIS_CS_WDT_SUB 3
`define LIS_CS_WT_MAIN 4
`define LIS_CS_UART0_EXT 5
`define LIS_CS_SUB_USED 6
`define LIS_CS_CSI_LSB 8
`define LIS_NUM_CSI 5
`define LIS_PRIO_W 3
`define LIS_CTRL_RESET 4'h0
`define LIS_MODE_RESET 2'h3
`define LIS_CS_RESET 13'h0000
`endif

// file: logic/lis_idle_ctrl.sv
// light idle standby controller with wishbone register slave
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "lis_defines.svh"
module lis_idle_ctrl (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire lis_pkg::lis_req_type i_req,
    input wire lis_pkg::lis_cpu_type i_cpu,
    output lis_pkg::lis_gate_type o_gate,
    output logic o_idle,
    output logic o_ack_nmi,
    output logic o_ack_mask,
    output logic o_sys_reset
);
    import lis_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        lis_phase_type phase;
        logic [3:0] ctrl;
        logic [1:0] mode;
        logic [12:0] clksel;
        logic ack;
        logic [31:0] rdata;
        logic ack_nmi;
        logic ack_mask;
        logic sys_reset;
        logic entry_refused;
        logic [7:0] wake_count;
    } lis_state_type;

    lis_state_type st;
    lis_state_type next_st;
    logic wake;
    logic dec_nmi;
    logic dec_mask;
    logic wb_req;
    logic wr_ctrl;

    lis_release_decode u_decode (
        .i_req(i_req),
        .i_cpu(i_cpu),
        .i_ctrl(st.ctrl),
        .o_wake(wake),
        .o_ack_nmi(dec_nmi),
        .o_ack_mask(dec_mask)
    );

    function automatic logic [31:0] read_reg(input lis_state_type s,
                                             input logic [3:0] adr);
        logic [31:0] v;
        v = 32'h00000000;
        case (adr)
            `LIS_ADR_CTRL: v[3:0] = s.ctrl;
            `LIS_ADR_MODE: v[1:0] = s.mode;
            `LIS_ADR_CLKSEL: v[12:0] = s.clksel;
            `LIS_ADR_STATUS: v = {23'h000000, s.wake_count,
                                  s.entry_refused};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction : read_reg

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack_nmi = 1'b0;
        next_st.ack_mask = 1'b0;
        next_st.sys_reset = 1'b0;
        wb_req = i_wb_cyc && i_wb_stb && !st.ack;
        next_st.ack = wb_req;
        wr_ctrl = 1'b0;
        if (wb_req) begin
            next_st.rdata = read_reg(st, i_wb_adr);
        end
        if (wb_req && i_wb_we && i_wb_sel[0]) begin
            case (i_wb_adr)
                `LIS_ADR_CTRL: begin
                    next_st.ctrl = i_wb_dat[3:0];
                    wr_ctrl = 1'b1;
                end
                `LIS_ADR_MODE: next_st.mode = i_wb_dat[1:0];
                `LIS_ADR_CLKSEL: begin
                    next_st.clksel[7:0] = i_wb_dat[7:0];
                    if (i_wb_sel[1]) begin
                        next_st.clksel[12:8] = i_wb_dat[12:8];
                    end
                end
                `LIS_ADR_STATUS: next_st.entry_refused = 1'b0;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        // trigger bit is never held; it clears in the cycle it is written, whether acted on or not
        next_st.ctrl[`LIS_CTRL_TRIG] = 1'b0;
        case (st.phase)
            LIS_RUN: begin
                if (wr_ctrl && i_wb_dat[`LIS_CTRL_TRIG] &&
                    st.mode == `LIS_MODE_LIGHT) begin
                    if (wake) begin
                        next_st.entry_refused = 1'b1;
                    end else begin
                        next_st.phase = LIS_IDLE;
                    end
                end
            end
            LIS_IDLE: begin
                if (i_req.reset_req) begin
                    // reset wins over any interrupt
                    next_st.phase = LIS_RUN;
                    next_st.sys_reset = 1'b1;
                end else if (wake) begin
                    // no stabilisation wait on exit
                    next_st.phase = LIS_RUN;
                    next_st.ack_nmi = dec_nmi;
                    next_st.ack_mask = dec_mask;
                    next_st.wake_count = st.wake_count + 8'h01;
                end
            end
            default: next_st.phase = LIS_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st.phase <= LIS_RUN;
            st.ctrl <= `LIS_CTRL_RESET;
            st.mode <= `LIS_MODE_RESET;
            st.clksel <= `LIS_CS_RESET;
            st.ack <= 1'b0;
            st.rdata <= 32'h00000000;
            st.ack_nmi <= 1'b0;
            st.ack_mask <= 1'b0;
            st.sys_reset <= 1'b0;
            st.entry_refused <= 1'b0;
            st.wake_count <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs and clock gating
    // ****************************************
    logic idle;
    logic sub_used;
    assign idle = (st.phase == LIS_IDLE);
    assign sub_used = st.clksel[`LIS_CS_SUB_USED];
    assign o_idle = idle;
    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.rdata;
    assign o_ack_nmi = st.ack_nmi;
    assign o_ack_mask = st.ack_mask;
    assign o_sys_reset = st.sys_reset;

    always_comb begin
        o_gate.osc_pll_flash_en = 1'b1;
        o_gate.cpu_clk_en = !idle;
        o_gate.dma_clk_en = !idle;
        o_gate.timer_pq_clk_en = !idle;
        o_gate.iic_clk_en = !idle;
        o_gate.uartc_clk_en = !idle;
        o_gate.crc_clk_en = !idle;
        // release path of the intc stays alive outside this gate
        o_gate.intc_clk_en = !idle;
        o_gate.timer_m_clk_en = !idle || st.clksel[`LIS_CS_TMM_FR8] ||
            (sub_used && st.clksel[`LIS_CS_TMM_SUB]);
        o_gate.wdt2_clk_en = !idle || st.clksel[`LIS_CS_WDT_FR8] ||
            (sub_used && st.clksel[`LIS_CS_WDT_SUB]);
        o_gate.watch_clk_en = !idle || sub_used ||
            st.clksel[`LIS_CS_WT_MAIN];
        o_gate.csi_clk_en = {`LIS_NUM_CSI{!idle}} |
            st.clksel[`LIS_CS_CSI_LSB +: `LIS_NUM_CSI];
        o_gate.uart0_clk_en = !idle ||
            st.clksel[`LIS_CS_UART0_EXT];
        o_gate.uart_other_clk_en = !idle;
        o_gate.adc_hold = idle;
        o_gate.dac_hold = idle;
        o_gate.rto_hold = idle;
        o_gate.key_int_en = 1'b1;
        o_gate.port_hold = idle;
    end

    // ****************************************
    // assertions
    // ****************************************
    // one idle cycle with a live release source and no reset
    sequence idle_wake_s;
        idle && !i_req.reset_req && wake;
    endsequence

    // the cycle after a release: back in run, cpu clock open
    sequence run_again_s;
        !idle && o_gate.cpu_clk_en;
    endsequence

    // a control write that asks for light idle
    sequence trig_write_s;
        !idle && wr_ctrl && i_wb_dat[`LIS_CTRL_TRIG] &&
            st.mode == `LIS_MODE_LIGHT;
    endsequence

    masked_no_wake_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && !i_req.reset_req && st.ctrl[2:0] == 3'h7 |=> idle)
        else $error("masked source released idle");
    wake_exit_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle_wake_s |=> !idle)
        else $error("unmasked request did not release");
    no_wait_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle_wake_s |=> run_again_s)
        else $error("cpu clock not restored at once");
    nmi_ack_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (idle_wake_s and dec_nmi) |=> o_ack_nmi)
        else $error("nmi not acknowledged at release");
    ack_once_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        o_ack_nmi |=> !o_ack_nmi)
        else $error("nmi acknowledge longer than a cycle");
    disabled_pend_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && !i_cpu.int_enabled |=> !o_ack_mask)
        else $error("maskable acked while disabled");
    high_prio_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && i_cpu.in_service &&
        i_req.mask_prio >= i_cpu.service_prio |=> !o_ack_mask)
        else $error("waker acked over higher service");
    low_prio_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (idle_wake_s and (i_req.maskable && !i_req.wdt_nmi &&
        !i_req.pin_nmi && !st.ctrl[`LIS_CTRL_MASKABLE_RELEASE_MASK] &&
        i_cpu.int_enabled && i_cpu.in_service &&
        i_req.mask_prio < i_cpu.service_prio)) |=> o_ack_mask)
        else $error("lower service blocked the waker");
    refuse_entry_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !idle && wake |=> !idle)
        else $error("entered idle with request pending");
    refused_flag_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (trig_write_s and wake) |=> st.entry_refused)
        else $error("refused entry not flagged");
    entry_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (trig_write_s and !wake) |=> idle)
        else $error("trigger did not enter idle");
    reset_exit_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && i_req.reset_req |=> o_sys_reset && !idle)
        else $error("reset request not honoured");
    osc_kept_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> o_gate.osc_pll_flash_en && !o_gate.cpu_clk_en)
        else $error("oscillator path or cpu clock wrong in idle");
    gate_idle_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> !o_gate.dma_clk_en && o_gate.adc_hold &&
        o_gate.port_hold)
        else $error("peripheral not gated");
    halt_units_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> !(o_gate.timer_pq_clk_en || o_gate.iic_clk_en ||
        o_gate.uartc_clk_en || o_gate.crc_clk_en ||
        o_gate.intc_clk_en))
        else $error("halted unit still clocked");
    run_open_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        !idle |-> o_gate.cpu_clk_en && o_gate.dma_clk_en &&
        !o_gate.adc_hold && !o_gate.port_hold)
        else $error("unit gated while running");
    timer_m_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && !st.clksel[`LIS_CS_TMM_FR8] && !sub_used
        |-> !o_gate.timer_m_clk_en)
        else $error("timer m runs on a stopped clock");
    wdt2_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && !st.clksel[`LIS_CS_WDT_FR8] && !sub_used
        |-> !o_gate.wdt2_clk_en)
        else $error("watchdog runs on a stopped clock");
    watch_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle && sub_used |-> o_gate.watch_clk_en)
        else $error("watch timer stopped with subclock");
    csi_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> o_gate.csi_clk_en ==
        st.clksel[`LIS_CS_CSI_LSB +: `LIS_NUM_CSI])
        else $error("clocked serial gate wrong in idle");
    uart_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> !o_gate.uart_other_clk_en &&
        o_gate.uart0_clk_en == st.clksel[`LIS_CS_UART0_EXT])
        else $error("async serial gate wrong in idle");
    conv_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> o_gate.adc_hold && o_gate.dac_hold)
        else $error("converter not frozen");
    rto_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> o_gate.rto_hold)
        else $error("real-time output not held");
    key_int_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        o_gate.key_int_en)
        else $error("key interrupt disabled");
    port_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        idle |-> o_gate.port_hold)
        else $error("ports not held in idle");
    bus_ack_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus ack late");
    ack_drop_a: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        o_wb_ack |=> !o_wb_ack)
        else $error("bus ack held");
endmodule : lis_idle_ctrl
`default_nettype wire

// file: logic/lis_pkg.sv
// types of the light idle standby controller
package lis_pkg;
    typedef enum {
        LIS_RUN,
        LIS_IDLE
    } lis_phase_type;
    typedef struct packed {
        logic wdt_nmi;
        logic pin_nmi;
        logic maskable;
        logic [2:0] mask_prio;
        logic nmi_nested;
        logic reset_req;
    } lis_req_type;
    typedef struct packed {
        logic int_enabled;
        logic in_service;
        logic [2:0] service_prio;
    } lis_cpu_type;
    typedef struct packed {
        logic cpu_clk_en;
        logic dma_clk_en;
        logic timer_pq_clk_en;
        logic iic_clk_en;
        logic uartc_clk_en;
        logic crc_clk_en;
        logic intc_clk_en;
        logic timer_m_clk_en;
        logic wdt2_clk_en;
        logic watch_clk_en;
        logic [4:0] csi_clk_en;
        logic uart0_clk_en;
        logic uart_other_clk_en;
        logic adc_hold;
        logic dac_hold;
        logic rto_hold;
        logic key_int_en;
        logic port_hold;
        logic osc_pll_flash_en;
    } lis_gate_type;
endpackage : lis_pkg

// file: logic/lis_release_decode.sv
// release and acknowledge decision for light idle
`timescale 1ns/1ns
`default_nettype none
`include "lis_defines.svh"
module lis_release_decode (
    input wire lis_pkg::lis_req_type i_req,
    input wire lis_pkg::lis_cpu_type i_cpu,
    input wire logic [3:0] i_ctrl,
    output logic o_wake,
    output logic o_ack_nmi,
    output logic o_ack_mask
);
    import lis_pkg::*;
    logic nmi_ok;
    logic mask_ok;
    always_comb begin
        // masked sources are ignored entirely
        nmi_ok = (i_req.wdt_nmi && !i_ctrl[`LIS_CTRL_WATCHDOG_NMI_RELEASE_MASK]) ||
                 (i_req.pin_nmi && !i_ctrl[`LIS_CTRL_PIN_NMI_RELEASE_MASK]);
        mask_ok = i_req.maskable && !i_ctrl[`LIS_CTRL_MASKABLE_RELEASE_MASK];
        // any priority releases
        o_wake = nmi_ok || mask_ok;
        // non-nested nmi is taken regardless of enable state
        o_ack_nmi = nmi_ok && !i_req.nmi_nested;
        // disabled: pending higher service: pending lower: ack
        o_ack_mask = mask_ok && !o_ack_nmi && i_cpu.int_enabled &&
            (!i_cpu.in_service || (i_req.mask_prio < i_cpu.service_prio));
    end
endmodule : lis_release_decode
`default_nettype wire
